// [bac_pkg.sv]
// package: constants for the boot and option configuration block
package bac_pkg;
  // chip-control command values
  localparam logic [7:0] CHIP_CTRL_LOADER_IDLE = 8'h03;
  localparam logic [7:0] CHIP_CTRL_APP_IDLE = 8'h01;
  localparam logic [7:0] CHIP_CTRL_SW_REBOOT = 8'h83;
  localparam logic [7:0] CHIP_CTRL_RESET = 8'h00;
  // option byte 0 field positions
  localparam int OB0_READ_LOCK_N = 0;
  localparam int OB0_TABLE_INHIBIT_N = 1;
  localparam int OB0_DATA_LOCK_N = 2;
  localparam int OB0_REBOOT_AB_DIS = 4;
  localparam int OB0_REBOOT_C_DIS = 5;
  localparam int OB0_FAST_XTAL = 7;
  // option byte 1 field positions
  localparam int OB1_ODD_EN_N = 0;
  localparam int OB1_EVEN_EN_N = 1;
  localparam int OB1_ODD_LEVEL = 2;
  localparam int OB1_EVEN_LEVEL = 3;
  localparam int OB1_CH6_EN_N = 6;
  localparam int OB1_CH7_EN_N = 7;
  // reset value of option bytes before capture (erased flash)
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  // cpu reset pulse length after a boot switch
  localparam int CPU_RST_NS = 100;
  localparam int CLK_PERIOD_NS = 25;
  localparam int CPU_RST_CYCLES = (CPU_RST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] CPU_RST_CNT = 4'(CPU_RST_CYCLES);
  // boot sequencer states, one-hot
  typedef enum logic [2:0] {
    BAC_RUN = 3'h1,
    BAC_SWITCH = 3'h2,
    BAC_RESET = 3'h4
  } bac_state_t;
endpackage

// [bac_opt_latch.sv]
// one option byte captured once at power-up
`timescale 1ns/1ps
`default_nettype none
module bac_opt_latch (
  input wire logic ref_clk, // system clock
  input wire logic sys_rst, // synchronous reset
  input wire logic capture, // one-shot capture strobe
  input wire logic [7:0] flash_byte, // byte read from option flash
  output logic [7:0] opt_byte, // latched option byte
  output logic opt_valid // byte has been captured
);
  // capture once, then hold for the rest of the power cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      opt_byte <= bac_pkg::OPTION_RESET;
      opt_valid <= 1'b0;
    end else if (capture && !opt_valid) begin
      opt_byte <= flash_byte;
      opt_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [bac_boot_config.sv]
// top: boot-source selection and option-byte decoding
//
// Notes on behaviour
// RULE1: chip control 03H at idle: loader, reset
// RULE2: hardware reboot also selects loader flash
// RULE3: writing 83H resets into application flash
// RULE4: chip control 01H at idle: no switch
// RULE5: option bytes captured once at power-up
// RULE6: option-0 bit 0 low blocks all reads
// RULE7: option-0 bit 1 low: external tables external
// RULE8: internal table reads always reach both memories
// RULE9: option-0 bit 1 high: no table restriction
// RULE10: option-0 bit 2 low locks data flash
// RULE11: pins a,b low at reset reboot loader
// RULE12: pin c low at reset reboots loader
// RULE13: programmer sets crystal range bit correctly
// RULE14: option-1 bit 0 low enables odd pwm
// RULE15: option-1 bit 1 low enables even pwm
// RULE16: option-1 bit 2 sets odd initial level
// RULE17: option-1 bit 3 sets even initial level
// RULE18: option-1 bit 6 low enables pwm 6
// RULE19: option-1 bit 7 low enables pwm 7
// RULE20: reserved option bits change nothing
`timescale 1ns/1ps
`default_nettype none
module bac_boot_config (
  input wire logic ref_clk, // 40 MHz cpu clock
  input wire logic sys_rst, // power-on reset, synchronous, high
  input wire logic ext_rst, // external reset pin level, high = in reset
  input wire logic [7:0] option_flash_0, // option byte 0 as stored in flash
  input wire logic [7:0] option_flash_1, // option byte 1 as stored in flash
  input wire logic chip_ctrl_we, // write strobe for chip control
  input wire logic [7:0] chip_ctrl_wdata, // chip control write data
  input wire logic cpu_idle_enter, // pulse: cpu enters idle
  input wire logic reboot_pin_a, // reboot strap pin a
  input wire logic reboot_pin_b, // reboot strap pin b
  input wire logic reboot_pin_c, // reboot strap pin c
  input wire logic read_req_flash, // read of program flash contents
  input wire logic read_req_special, // read of special setting registers
  input wire logic table_read, // code table read request
  input wire logic table_from_internal, // table read issued from internal code
  input wire logic table_addr_internal, // table target lies in internal memory
  input wire logic data_flash_req, // data flash access request
  output logic [7:0] chip_control_reg, // current chip control value
  output logic fetch_from_loader, // 1: fetch from loader flash
  output logic cpu_rst, // cpu reset request
  output logic read_allow, // flash/special read permitted
  output logic table_internal_allow, // table read may return internal code
  output logic data_flash_allow, // data flash access permitted
  output logic fast_xtal, // crystal range above 24 MHz
  output logic [5:0] pwm_pin_en, // per-channel pwm push-pull enables, ch0..5
  output logic pwm_ch6_en, // pwm 6 push-pull enable
  output logic pwm_ch7_en, // pwm 7 push-pull enable
  output logic odd_pwm_initial_level, // odd pwm level after cpu reset
  output logic even_pwm_initial_level, // even pwm level after cpu reset
  output logic options_valid // option bytes captured
);
  logic [7:0] option_byte_0;
  logic [7:0] option_byte_1;
  logic ob0_valid;
  logic ob1_valid;
  logic capture_done;
  bac_pkg::bac_state_t state;
  bac_pkg::bac_state_t next_state;
  logic [3:0] rst_cnt;
  logic hw_reboot;

  // how the block fits together:
  // - the two option bytes are read from flash once, on the first edge after
  //   power-on reset, and then held until the next power cycle; an external
  //   reset does not refresh them, so a programmer must power-cycle the part
  //   to see a new configuration
  // - until both bytes are held, the read and data flash permits and every pin enable stay off and the
  //   cpu is held in reset; the table permit already follows bit 1 of the erased-flash byte 0
  // - the boot sequencer only acts from the run state; a reboot command that
  //   arrives while a switch or a cpu reset is under way is ignored
  // - a loader switch requested by chip control takes effect at idle entry,
  //   one cycle through the switch state, then a fixed-length cpu reset
  // - a software reboot returns fetch to the application flash at once and
  //   starts the same fixed-length cpu reset
  // - the strap pins are looked at on every cycle the external reset is high,
  //   so the last cycle of the reset pulse decides the boot source
  // - chip control clears on any reset, so a stale 03H or 83H cannot be
  //   applied again after the cpu restarts
  // - the access request inputs are not used here: the permits are levels
  //   that the memory paths combine with their own requests

  // option bytes, captured in the first cycle after power-on
  bac_opt_latch u_ob0 ( // RULE5
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .capture(!capture_done),
    .flash_byte(option_flash_0),
    .opt_byte(option_byte_0),
    .opt_valid(ob0_valid)
  );
  bac_opt_latch u_ob1 ( // RULE5
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .capture(!capture_done),
    .flash_byte(option_flash_1),
    .opt_byte(option_byte_1),
    .opt_valid(ob1_valid)
  );
  assign capture_done = ob0_valid & ob1_valid;

  // hardware reboot request while external reset is held
  // gated by capture so erased-flash defaults never enable the straps
  always_comb begin
    hw_reboot = 1'b0;
    if (capture_done && ext_rst) begin
      if (!option_byte_0[bac_pkg::OB0_REBOOT_AB_DIS] && !reboot_pin_a && !reboot_pin_b) begin
        hw_reboot = 1'b1; // RULE11
      end
      if (!option_byte_0[bac_pkg::OB0_REBOOT_C_DIS] && !reboot_pin_c) begin
        hw_reboot = 1'b1; // RULE12
      end
    end
  end

  // chip control register; cleared by any reset
  // clearing in the reset state stops a command from firing twice
  always_ff @(posedge ref_clk) begin
    if (sys_rst || ext_rst || state == bac_pkg::BAC_RESET) begin
      chip_control_reg <= bac_pkg::CHIP_CTRL_RESET;
    end else if (chip_ctrl_we) begin
      chip_control_reg <= chip_ctrl_wdata;
    end
  end

  // boot sequencer next state
  // a reboot write wins over an idle entry in the same cycle
  always_comb begin
    next_state = state;
    case (state)
      bac_pkg::BAC_RUN: begin
        if (chip_ctrl_we && chip_ctrl_wdata == bac_pkg::CHIP_CTRL_SW_REBOOT) begin
          next_state = bac_pkg::BAC_RESET; // RULE3
        end else if (cpu_idle_enter && chip_control_reg == bac_pkg::CHIP_CTRL_LOADER_IDLE) begin
          next_state = bac_pkg::BAC_SWITCH; // RULE1
        end
      end
      bac_pkg::BAC_SWITCH: begin
        next_state = bac_pkg::BAC_RESET;
      end
      bac_pkg::BAC_RESET: begin
        if (rst_cnt == 4'h0) begin
          next_state = bac_pkg::BAC_RUN;
        end
      end
      default: begin
        next_state = bac_pkg::BAC_RUN;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk) begin
    if (sys_rst || ext_rst) begin
      state <= bac_pkg::BAC_RUN;
    end else begin
      state <= next_state;
    end
  end

  // cpu reset pulse length counter
  // preloaded outside the reset state so every pulse has the same length
  always_ff @(posedge ref_clk) begin
    if (sys_rst || state != bac_pkg::BAC_RESET) begin
      rst_cnt <= bac_pkg::CPU_RST_CNT - 4'h1;
    end else if (rst_cnt != 4'h0) begin
      rst_cnt <= rst_cnt - 4'h1;
    end
  end

  // boot source; idle with 01H leaves it untouched
  // a strap request outranks the external reset's return to application flash
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fetch_from_loader <= 1'b0;
    end else if (hw_reboot) begin
      fetch_from_loader <= 1'b1; // RULE2
    end else if (ext_rst) begin
      fetch_from_loader <= 1'b0;
    end else if (state == bac_pkg::BAC_SWITCH) begin
      fetch_from_loader <= 1'b1; // RULE1
    end else if (state == bac_pkg::BAC_RUN && chip_ctrl_we
                 && chip_ctrl_wdata == bac_pkg::CHIP_CTRL_SW_REBOOT) begin
      fetch_from_loader <= 1'b0; // RULE3
    end
  end

  // cpu reset output: power-on, external pin, or sequencer reset; no reset for 01H (RULE4)
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cpu_rst <= 1'b1;
    end else begin
      cpu_rst <= ext_rst || !capture_done || next_state == bac_pkg::BAC_RESET;
    end
  end

  // read permit for flash contents and special registers; bit 3 unused (RULE20)
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      read_allow <= 1'b0;
    end else begin
      read_allow <= option_byte_0[bac_pkg::OB0_READ_LOCK_N] && capture_done; // RULE6
    end
  end

  // table read permit: internal code may always reach both memories
  // the source flag is a level, so the permit trails it by one cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      table_internal_allow <= 1'b0;
    end else if (table_from_internal) begin
      table_internal_allow <= 1'b1; // RULE8
    end else begin
      table_internal_allow <= option_byte_0[bac_pkg::OB0_TABLE_INHIBIT_N]; // RULE7 RULE9
    end
  end

  // data flash permit; held off until the bytes are captured
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      data_flash_allow <= 1'b0;
    end else begin
      data_flash_allow <= option_byte_0[bac_pkg::OB0_DATA_LOCK_N] && capture_done; // RULE10
    end
  end

  // crystal range bit passed through; bit 6 unused (RULE20)
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      fast_xtal <= 1'b0;
    end else begin
      fast_xtal <= option_byte_0[bac_pkg::OB0_FAST_XTAL]; // RULE13
    end
  end

  // pwm pin enables ch0..5, one option bit per group; bits 4 and 5 unused (RULE20)
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwm_pin_en <= 6'h00;
    end else begin
      for (int i = 0; i < 6; i++) begin
        if (i % 2 == 1) begin
          pwm_pin_en[i] <= !option_byte_1[bac_pkg::OB1_ODD_EN_N] && capture_done; // RULE14
        end else begin
          pwm_pin_en[i] <= !option_byte_1[bac_pkg::OB1_EVEN_EN_N] && capture_done; // RULE15
        end
      end
    end
  end

  // channel 6 push-pull enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwm_ch6_en <= 1'b0;
    end else begin
      pwm_ch6_en <= !option_byte_1[bac_pkg::OB1_CH6_EN_N] && capture_done; // RULE18
    end
  end

  // channel 7 push-pull enable
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      pwm_ch7_en <= 1'b0;
    end else begin
      pwm_ch7_en <= !option_byte_1[bac_pkg::OB1_CH7_EN_N] && capture_done; // RULE19
    end
  end

  // odd channel level after cpu reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      odd_pwm_initial_level <= 1'b0;
    end else begin
      odd_pwm_initial_level <= option_byte_1[bac_pkg::OB1_ODD_LEVEL]; // RULE16
    end
  end

  // even channel level after cpu reset
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      even_pwm_initial_level <= 1'b0;
    end else begin
      even_pwm_initial_level <= option_byte_1[bac_pkg::OB1_EVEN_LEVEL]; // RULE17
    end
  end

  // capture flag, aligned with the decoded outputs above
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      options_valid <= 1'b0;
    end else begin
      options_valid <= capture_done;
    end
  end
endmodule
`default_nettype wire

// [bac_boot_config_sva.sv]
// checker: port assertions for the boot and option block
`timescale 1ns/1ps
`default_nettype none
module bac_sva_check (
  input wire logic ref_clk, // clock
  input wire logic sys_rst, // power-on reset
  input wire logic ext_rst, // pin reset
  input wire logic [7:0] option_flash_0, // byte 0
  input wire logic [7:0] option_flash_1, // byte 1
  input wire logic chip_ctrl_we, // strobe
  input wire logic [7:0] chip_ctrl_wdata, // data
  input wire logic cpu_idle_enter, // idle pulse
  input wire logic reboot_pin_a, // strap a
  input wire logic reboot_pin_b, // strap b
  input wire logic reboot_pin_c, // strap c
  input wire logic table_from_internal, // table source
  input wire logic [7:0] chip_control_reg, // control
  input wire logic fetch_from_loader, // boot source
  input wire logic cpu_rst, // cpu reset
  input wire logic read_allow, // read permit
  input wire logic table_internal_allow, // table permit
  input wire logic data_flash_allow, // data permit
  input wire logic [5:0] pwm_pin_en, // pwm 0..5
  input wire logic pwm_ch6_en, // pwm 6
  input wire logic pwm_ch7_en, // pwm 7
  input wire logic odd_pwm_initial_level, // odd level
  input wire logic even_pwm_initial_level, // even level
  input wire logic options_valid // captured
);
  logic arm;
  logic [7:0] c0;
  logic [7:0] c1;
  logic hw_req;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (sys_rst);
  // shadow of the bytes, taken on the first edge after power-on reset
  always_ff @(posedge ref_clk) begin
    arm <= sys_rst;
    if (arm && !sys_rst) begin
      c0 <= option_flash_0;
      c1 <= option_flash_1;
    end
  end
  assign hw_req = (!c0[4] && !reboot_pin_a && !reboot_pin_b) || (!c0[5] && !reboot_pin_c);
  AST_PROT: assert property (options_valid |-> read_allow == c0[0] && data_flash_allow == c0[2])
    else $error("read or data flash permit wrong");
  AST_TABLE: assert property (options_valid && $past(options_valid) |->
    table_internal_allow == ($past(table_from_internal) || c0[1])) else $error("table permit wrong");
  AST_PWM_EN: assert property (options_valid |-> pwm_pin_en == {3{~c1[0], ~c1[1]}} &&
    pwm_ch6_en == !c1[6] && pwm_ch7_en == !c1[7]) else $error("pwm enables wrong");
  AST_PWM_LVL: assert property (options_valid |-> odd_pwm_initial_level == c1[2] &&
    even_pwm_initial_level == c1[3]) else $error("pwm levels wrong");
  AST_SW_BOOT: assert property (chip_ctrl_we && chip_ctrl_wdata == bac_pkg::CHIP_CTRL_SW_REBOOT &&
    !cpu_rst && !ext_rst && options_valid |=> cpu_rst && !fetch_from_loader) else $error("soft reboot wrong");
  AST_RST_LEN: assert property ($rose(cpu_rst) && !ext_rst |-> cpu_rst [*4] ##1 !cpu_rst)
    else $error("cpu reset length wrong");
  AST_IDLE_LDR: assert property (cpu_idle_enter && chip_control_reg == bac_pkg::CHIP_CTRL_LOADER_IDLE &&
    !cpu_rst && !ext_rst |-> ##2 fetch_from_loader && cpu_rst) else $error("idle loader switch wrong");
  AST_IDLE_APP: assert property (cpu_idle_enter && chip_control_reg == bac_pkg::CHIP_CTRL_APP_IDLE &&
    !cpu_rst && !ext_rst |=> (!cpu_rst && $stable(fetch_from_loader)) [*3]) else $error("idle app wrong");
  AST_HW_BOOT: assert property (ext_rst && options_valid |=> fetch_from_loader == $past(hw_req))
    else $error("pin reboot wrong");
  COV_SW: cover property (chip_ctrl_we && chip_ctrl_wdata == bac_pkg::CHIP_CTRL_SW_REBOOT ##1 cpu_rst);
  COV_HW: cover property (ext_rst && hw_req ##1 fetch_from_loader);
  COV_IDLE: cover property (cpu_idle_enter ##2 fetch_from_loader && cpu_rst);
endmodule
bind bac_boot_config bac_sva_check i_chk (.ref_clk, .sys_rst, .ext_rst, .option_flash_0, .option_flash_1,
  .chip_ctrl_we, .chip_ctrl_wdata, .cpu_idle_enter, .reboot_pin_a, .reboot_pin_b, .reboot_pin_c,
  .table_from_internal, .chip_control_reg, .fetch_from_loader, .cpu_rst, .read_allow, .table_internal_allow,
  .data_flash_allow, .pwm_pin_en, .pwm_ch6_en, .pwm_ch7_en, .odd_pwm_initial_level, .even_pwm_initial_level,
  .options_valid);
`default_nettype wire

// [bac_partner.sv]
// partner: programmed option bytes and strap pins with pull-ups
`timescale 1ns/1ps
`default_nettype none
module bac_partner #(
  parameter int XTAL_MHZ = 40 // crystal fitted on the board
) (
  input wire logic [7:0] image_0, // byte 0 as programmed
  input wire logic [7:0] image_1, // byte 1 as programmed
  input wire logic [2:0] strap_low, // straps held low: c, b, a
  output logic [7:0] option_flash_0, // stored byte 0
  output logic [7:0] option_flash_1, // stored byte 1
  output logic reboot_pin_a, // strap a
  output logic reboot_pin_b, // strap b
  output logic reboot_pin_c // strap c
);
  // programmer fills the crystal range bit from the fitted crystal
  assign option_flash_0 = {XTAL_MHZ > 24, image_0[6:0]};
  assign option_flash_1 = image_1;
  // released straps rise to the pull-up level
  assign reboot_pin_a = !strap_low[0];
  assign reboot_pin_b = !strap_low[1];
  assign reboot_pin_c = !strap_low[2];
endmodule
`default_nettype wire

// [test_bac_boot_config.sv]
// testbench: boot source switching and option byte decoding
`timescale 1ns/1ps
`default_nettype none
module test_bac_boot_config;
  logic ref_clk = 1'b0, sys_rst = 1'b1, ext_rst = 1'b0, chip_ctrl_we = 1'b0, cpu_idle_enter = 1'b0;
  logic table_from_internal = 1'b0;
  logic [7:0] chip_ctrl_wdata = 8'h00, img0 = 8'hFF, img1 = 8'hFF, option_flash_0, option_flash_1;
  logic [7:0] chip_control_reg;
  logic [2:0] strap = 3'h0;
  logic [5:0] pwm_pin_en;
  logic reboot_pin_a, reboot_pin_b, reboot_pin_c, fetch_from_loader, cpu_rst, read_allow, table_internal_allow;
  logic data_flash_allow, fast_xtal, pwm_ch6_en, pwm_ch7_en, odd_pwm_initial_level, even_pwm_initial_level;
  logic options_valid;
  logic slow_sel = 1'b0;
  logic [7:0] slow_flash_0;
  int failures = 0, checks_done = 0, cycles = 0;
  // byte 0, byte 1, then read, data, table, xtal, pwm[5:0], ch6, ch7, odd, even
  logic [29:0] rows [3] = '{{8'hFF, 8'hFF, 14'h3C03}, {8'h4A, 8'h35, 14'h0D5E}, {8'h00, 8'h00, 14'h07FC}};
  // straps held low {c, b, a} and the boot source expected
  logic [3:0] straps [3] = '{4'h7, 4'h9, 4'h2};
  bac_partner i_far (.image_0(img0), .image_1(img1), .strap_low(strap), .option_flash_0, .option_flash_1,
    .reboot_pin_a, .reboot_pin_b, .reboot_pin_c);
  // a second board with a slow crystal, so the range bit is seen both ways
  bac_partner #(.XTAL_MHZ(20)) i_far_slow (.image_0(img0), .image_1(img1), .strap_low(strap),
    .option_flash_0(slow_flash_0), .option_flash_1(), .reboot_pin_a(), .reboot_pin_b(), .reboot_pin_c());
  bac_boot_config i_dut (.ref_clk, .sys_rst, .ext_rst, .option_flash_0(slow_sel ? slow_flash_0 : option_flash_0),
    .option_flash_1, .chip_ctrl_we,
    .chip_ctrl_wdata, .cpu_idle_enter, .reboot_pin_a, .reboot_pin_b, .reboot_pin_c, .read_req_flash(1'b0),
    .read_req_special(1'b0), .table_read(1'b0), .table_from_internal, .table_addr_internal(1'b0),
    .data_flash_req(1'b0), .chip_control_reg, .fetch_from_loader, .cpu_rst, .read_allow, .table_internal_allow,
    .data_flash_allow, .fast_xtal, .pwm_pin_en, .pwm_ch6_en, .pwm_ch7_en, .odd_pwm_initial_level,
    .even_pwm_initial_level, .options_valid);
  initial forever #12.5 ref_clk = ~ref_clk;
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // wait n rising edges, then settle to the falling edge
  task automatic look(input int n);
    repeat (n) @(posedge ref_clk);
    @(negedge ref_clk);
  endtask
  // one chip-control write, then optionally an idle pulse right after
  task automatic wr(input logic [7:0] v, input logic idle);
    @(posedge ref_clk);
    chip_ctrl_we <= 1'b1;
    chip_ctrl_wdata <= v;
    @(posedge ref_clk);
    chip_ctrl_we <= 1'b0;
    cpu_idle_enter <= idle;
    if (idle) begin
      @(posedge ref_clk);
      cpu_idle_enter <= 1'b0;
    end
  endtask
  task automatic final_report();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  // hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end
  initial begin
    foreach (rows[i]) begin
      @(posedge ref_clk);
      sys_rst <= 1'b1;
      img0 <= rows[i][29:22];
      img1 <= rows[i][21:14];
      repeat (5) @(posedge ref_clk);
      sys_rst <= 1'b0;
      look(3);
      chk({2'h0, read_allow, data_flash_allow, table_internal_allow, fast_xtal, pwm_pin_en, pwm_ch6_en, pwm_ch7_en,
        odd_pwm_initial_level, even_pwm_initial_level}, {2'h0, rows[i][13:0]});
      $display("option row %0d done", i);
    end
    slow_sel <= 1'b1;
    sys_rst <= 1'b1;
    repeat (5) @(posedge ref_clk);
    sys_rst <= 1'b0;
    look(3);
    chk({fast_xtal, read_allow}, 2'h0);
    $display("slow crystal test done");
    @(posedge ref_clk);
    table_from_internal <= 1'b1;
    look(2);
    chk(table_internal_allow, 1'b1);
    wr(bac_pkg::CHIP_CTRL_LOADER_IDLE, 1'b1);
    look(1);
    chk({cpu_rst, fetch_from_loader}, 2'h3);
    look(8);
    wr(bac_pkg::CHIP_CTRL_APP_IDLE, 1'b1);
    look(3);
    chk({cpu_rst, fetch_from_loader}, 2'h1);
    wr(bac_pkg::CHIP_CTRL_SW_REBOOT, 1'b0);
    look(0);
    chk({cpu_rst, fetch_from_loader}, 2'h2);
    look(4);
    chk(cpu_rst, 1'b0);
    $display("boot switch tests done");
    foreach (straps[i]) begin
      @(posedge ref_clk);
      ext_rst <= 1'b1;
      strap <= straps[i][3:1];
      repeat (3) @(posedge ref_clk);
      ext_rst <= 1'b0;
      strap <= 3'h0;
      look(0);
      chk(fetch_from_loader, straps[i][0]);
      look(8);
    end
    @(posedge ref_clk);
    img0 <= 8'h7F;
    img1 <= 8'hFF;
    look(3);
    chk({read_allow, pwm_pin_en, odd_pwm_initial_level}, {1'b0, 6'h3F, 1'b0});
    $display("pin reboot and hold tests done");
    final_report();
  end
endmodule
`default_nettype wire
